// ===== design/seq_stack_defs.vh
// Constants for the sequencer stack entries thirteen to fifteen
`ifndef SEQ_STACK_DEFS_VH
`define SEQ_STACK_DEFS_VH

// Register offsets
`define OFS_ENTRY_THIRTEEN 6'h2d
`define OFS_ENTRY_FOURTEEN 6'h2e
`define OFS_ENTRY_FIFTEEN 6'h2f
`define OFS_SEQ_CONTROL 6'h3a
`define OFS_SEQ_STATUS 6'h3b

// Reset values
`define RST_ENTRY_THIRTEEN 16'h5a00
`define RST_ENTRY_FOURTEEN 16'h5c00
`define RST_ENTRY_FIFTEEN 16'h5e00

// Field positions
`define FLD_ACCESS_DIR 15
`define FLD_ADDR_HI 14
`define FLD_ADDR_LO 9
`define FLD_LOOP_BACK 8
`define FLD_CHAN_B_HI 7
`define FLD_CHAN_B_LO 4
`define FLD_CHAN_A_HI 3
`define FLD_CHAN_A_LO 0

// Stack index of the first entry and count of the entries held here
`define FIRST_ENTRY 2'd0
`define ENTRY_COUNT 2'd3

// Conversion time in clock cycles, 1000 ns at a 10 ns clock
`define CONV_CYCLES 8'd100

`endif

// ===== design/stack_entry_reg.v
// One sequencer stack entry register with its own reset value
`timescale 1ns/10ps
`include "seq_stack_defs.vh"

module stack_entry_reg #(
    parameter [15:0] RESET_VALUE = 16'h0000
) (
    // Clock and reset
    input wire clk,
    input wire reset,
    // Write port
    input wire write_en,
    input wire [15:0] write_data,
    // Stored word
    output reg [15:0] entry_q
);

    // Whole word stores, direction bit included
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            entry_q <= RESET_VALUE;
        end else if (write_en) begin
            entry_q <= write_data;
        end
    end

endmodule

// ===== design/conv_timer.v
// Counts the cycles of one simultaneous conversion
`timescale 1ns/10ps
`include "seq_stack_defs.vh"

module conv_timer (
    // Clock and reset
    input wire clk,
    input wire reset,
    // Control
    input wire start,
    // Status
    output reg busy_q,
    output reg done_q
);

    localparam [7:0] LAST_COUNT = `CONV_CYCLES - 8'd1;

    reg [7:0] count_q;

    // Busy from start until the count runs out, then a done pulse
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            count_q <= 8'h00;
            busy_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            done_q <= 1'b0;
            if (busy_q) begin
                if (count_q == LAST_COUNT) begin
                    busy_q <= 1'b0;
                    done_q <= 1'b1;
                    count_q <= 8'h00;
                end else begin
                    count_q <= count_q + 8'h01;
                end
            end else if (start) begin
                busy_q <= 1'b1;
                count_q <= 8'h00;
            end
        end
    end

endmodule

// ===== design/seq_stack_block.v
// Sequencer stack entries thirteen to fifteen with stepping logic
// Overview of operation
// - Bit 15 selects write (1) or readback (0)
// - Bits 14:9 hold entry address, reset self
// - Return bit 0 advances to next entry
// - Return bit 1 goes back to first
// - Bits 7:4 select converter B channel
// - Bits 3:0 select converter A channel
// - Entries at 0x2d..0x2f, reset to own address
//
// The plain strobed port was chosen for this implementation.
`timescale 1ns/10ps
`include "seq_stack_defs.vh"

module seq_stack_block (
    // Clock and reset
    input wire clk,
    input wire reset,
    // Register port
    input wire [5:0] reg_addr,
    input wire [15:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [15:0] reg_rdata_q,
    // Converter channel selections, start pulse and current step
    output reg [3:0] converter_a_channel_q,
    output reg [3:0] converter_b_channel_q,
    output reg convert_start_q,
    output reg [1:0] step_index_q
);

    ////////////////////////////////////////////////////////////////////////////
    // Helper functions

    // Address field of a word
    function [5:0] addr_field;
        input [15:0] word;
        begin
            addr_field = word[`FLD_ADDR_HI:`FLD_ADDR_LO];
        end
    endfunction

    // Entry index for a register address, 3 when none matches
    function [1:0] entry_index;
        input [5:0] addr;
        begin
            case (addr)
                `OFS_ENTRY_THIRTEEN: entry_index = 2'd0;
                `OFS_ENTRY_FOURTEEN: entry_index = 2'd1;
                `OFS_ENTRY_FIFTEEN: entry_index = 2'd2;
                default: entry_index = 2'd3;
            endcase
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Register write decode

    wire [1:0] wr_index;
    wire wr_dir_ok;
    wire wr_addr_ok;
    wire [2:0] entry_we;
    wire [15:0] entry13;
    wire [15:0] entry14;
    wire [15:0] entry15;
    reg run_q;

    assign wr_index = entry_index(reg_addr);
    // Only a word marked as a write stores into an entry; the control register ignores bit 15
    assign wr_dir_ok = reg_wdata[`FLD_ACCESS_DIR];
    // The address field must name the targeted entry
    assign wr_addr_ok = (addr_field(reg_wdata) == reg_addr);
    assign entry_we[0] = reg_wr && wr_dir_ok && wr_addr_ok && (wr_index == 2'd0);
    assign entry_we[1] = reg_wr && wr_dir_ok && wr_addr_ok && (wr_index == 2'd1);
    assign entry_we[2] = reg_wr && wr_dir_ok && wr_addr_ok && (wr_index == 2'd2);

    ////////////////////////////////////////////////////////////////////////////
    // Entry storage, each reset to its own address

    stack_entry_reg #(.RESET_VALUE(`RST_ENTRY_THIRTEEN)) u_entry13 (
        .clk(clk),
        .reset(reset),
        .write_en(entry_we[0]),
        .write_data(reg_wdata),
        .entry_q(entry13)
    );

    stack_entry_reg #(.RESET_VALUE(`RST_ENTRY_FOURTEEN)) u_entry14 (
        .clk(clk),
        .reset(reset),
        .write_en(entry_we[1]),
        .write_data(reg_wdata),
        .entry_q(entry14)
    );

    stack_entry_reg #(.RESET_VALUE(`RST_ENTRY_FIFTEEN)) u_entry15 (
        .clk(clk),
        .reset(reset),
        .write_en(entry_we[2]),
        .write_data(reg_wdata),
        .entry_q(entry15)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer control register

    wire ctl_write;
    assign ctl_write = reg_wr && (reg_addr == `OFS_SEQ_CONTROL);

    // Bit 0 runs the sequencer
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            run_q <= 1'b0;
        end else if (ctl_write) begin
            run_q <= reg_wdata[0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer stepping

    localparam [1:0] ST_IDLE = 2'd0;
    localparam [1:0] ST_START = 2'd1;
    localparam [1:0] ST_WAIT = 2'd2;

    reg [1:0] state_q;
    reg [1:0] state_d;
    reg [1:0] step_d;
    reg [15:0] cur_entry;
    wire conv_busy;
    wire conv_done;

    conv_timer u_timer (
        .clk(clk),
        .reset(reset),
        .start(convert_start_q),
        .busy_q(conv_busy),
        .done_q(conv_done)
    );

    // Entry at the current step
    always @* begin
        case (step_index_q)
            2'd0: cur_entry = entry13;
            2'd1: cur_entry = entry14;
            default: cur_entry = entry15;
        endcase
    end

    // Next state and next step
    always @* begin
        state_d = state_q;
        step_d = step_index_q;
        case (state_q)
            ST_IDLE: begin
                step_d = `FIRST_ENTRY;
                if (run_q) begin
                    state_d = ST_START;
                end
            end
            ST_START: begin
                state_d = ST_WAIT;
            end
            ST_WAIT: begin
                if (conv_done) begin
                    if (cur_entry[`FLD_LOOP_BACK] || step_index_q == `ENTRY_COUNT - 2'd1) begin
                        step_d = `FIRST_ENTRY;
                    end else begin
                        step_d = step_index_q + 2'd1;
                    end
                    state_d = run_q ? ST_START : ST_IDLE;
                end
            end
            default: begin
                state_d = ST_IDLE;
                step_d = `FIRST_ENTRY;
            end
        endcase
    end

    // State, step and converter outputs
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            state_q <= ST_IDLE;
            step_index_q <= 2'd0;
            convert_start_q <= 1'b0;
            converter_a_channel_q <= 4'h0;
            converter_b_channel_q <= 4'h0;
        end else begin
            state_q <= state_d;
            step_index_q <= step_d;
            convert_start_q <= (state_q == ST_START);
            if (state_q == ST_START) begin
                converter_a_channel_q <= cur_entry[`FLD_CHAN_A_HI:`FLD_CHAN_A_LO];
                converter_b_channel_q <= cur_entry[`FLD_CHAN_B_HI:`FLD_CHAN_B_LO];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register readback

    // Read data stands the cycle after the strobe, zero otherwise
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            reg_rdata_q <= 16'h0000;
        end else if (reg_rd) begin
            case (reg_addr)
                `OFS_ENTRY_THIRTEEN: reg_rdata_q <= entry13;
                `OFS_ENTRY_FOURTEEN: reg_rdata_q <= entry14;
                `OFS_ENTRY_FIFTEEN: reg_rdata_q <= entry15;
                `OFS_SEQ_CONTROL: reg_rdata_q <= {15'h0000, run_q};
                `OFS_SEQ_STATUS: reg_rdata_q <= {11'h000, conv_busy, state_q, step_index_q};
                default: reg_rdata_q <= 16'h0000;
            endcase
        end else begin
            reg_rdata_q <= 16'h0000;
        end
    end

endmodule

// ===== sim/reg_host.sv
// Host model driving the register port
`timescale 1ns/10ps
module reg_host (
    // Clock
    input wire clk,
    // Register port
    output logic [5:0] reg_addr,
    output logic [15:0] reg_wdata,
    output logic reg_wr,
    output logic reg_rd,
    input wire [15:0] reg_rdata_q
);
    // Idle bus from time zero
    initial begin
        reg_addr = 6'h00;
        reg_wdata = 16'h0000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end
    // One-cycle write strobe
    task wr(input [5:0] a, input [15:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    // Entry word: write select plus own address
    function [15:0] ent(input [5:0] a, input lp, input [3:0] b, input [3:0] c);
        ent = {1'b1, a, lp, b, c};
    endfunction
    // Read; data taken in the cycle after the strobe
    task rd(input [5:0] a, output [15:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata_q;
    endtask
endmodule

// ===== sim/seq_stack_block_asserts.sv
// Checker for the sequencer stack block
`timescale 1ns/10ps
module seq_stack_block_asserts (
    // Clock and reset
    input wire clk,
    input wire reset,
    // Register port
    input wire [5:0] reg_addr,
    input wire [15:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    input wire [15:0] reg_rdata_q,
    // Converter side
    input wire [3:0] converter_a_channel_q,
    input wire [3:0] converter_b_channel_q,
    input wire convert_start_q,
    input wire [1:0] step_index_q
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    // Register port relations
    property p_rd_idle; !$past(reg_rd) |-> reg_rdata_q == 16'h0; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data without strobe");
    property p_rd_back; reg_wr && reg_wdata[15] && reg_wdata[14:9] == reg_addr && reg_addr[5:2] == 4'hb
        && reg_addr[1:0] != 2'h0 ##1 !reg_wr ##1 reg_rd && $stable(reg_addr) |=> reg_rdata_q == $past(reg_wdata, 3);
    endproperty
    a_rd_back: assert property (p_rd_back) else $error("entry readback differs");
    property p_unmapped; reg_rd && reg_addr == 6'h3f |=> reg_rdata_q == 16'h0; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    // Sequencer relations
    property p_start_gap; convert_start_q |=> !convert_start_q [*8]; endproperty
    a_start_gap: assert property (p_start_gap) else $error("start pulses too close");
    property p_step_hold; convert_start_q |=> $stable(step_index_q) [*8]; endproperty
    a_step_hold: assert property (p_step_hold) else $error("step moved mid conversion");
    property p_chan_hold; !convert_start_q |-> $stable(converter_a_channel_q) && $stable(converter_b_channel_q);
    endproperty
    a_chan_hold: assert property (p_chan_hold) else $error("channels moved off start");
    property p_step_next; $changed(step_index_q) |-> step_index_q == $past(step_index_q) + 2'd1
        || step_index_q == 2'd0; endproperty
    a_step_next: assert property (p_step_next) else $error("step jumped");
    property p_step_range; step_index_q != 2'd3; endproperty
    a_step_range: assert property (p_step_range) else $error("step out of range");
    // Main scenarios reached
    c_last: cover property (convert_start_q && step_index_q == 2'd2);
    c_wrap: cover property ($changed(step_index_q) && step_index_q == 2'd0);
    c_read: cover property (reg_rd ##1 reg_rdata_q != 16'h0);
endmodule
bind seq_stack_block seq_stack_block_asserts chk (.clk, .reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata_q, .converter_a_channel_q, .converter_b_channel_q, .convert_start_q, .step_index_q);

// ===== sim/seq_stack_block_tb.sv
// Testbench for the sequencer stack block
`timescale 1ns/10ps
module seq_stack_block_tb;
    logic clk = 1'b0;
    logic reset = 1'b1;
    wire [5:0] reg_addr;
    wire [15:0] reg_wdata, reg_rdata_q;
    wire reg_wr, reg_rd, convert_start_q;
    wire [3:0] converter_a_channel_q, converter_b_channel_q;
    wire [1:0] step_index_q;
    int error_cnt = 0;
    int n_compared = 0;
    int cycles = 0;
    logic [15:0] d;
    logic [5:0] a;
    seq_stack_block uut (.clk, .reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata_q,
        .converter_a_channel_q, .converter_b_channel_q, .convert_start_q, .step_index_q);
    reg_host host (.clk, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata_q);
    // Clock and hang limit
    always #5 clk = ~clk;
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            error_cnt++;
            tally_and_finish();
        end
    end
    task chk(input [15:0] got, input [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Bounded wait for the next start pulse
    task wait_start;
        int n;
        n = 0;
        @(posedge clk);
        #1;
        while (convert_start_q !== 1'b1 && n < 300) begin
            @(posedge clk);
            #1;
            n++;
        end
        if (convert_start_q !== 1'b1) error_cnt++;
    endtask
    task t_reset;
        for (int i = 0; i < 3; i++) begin
            host.rd(6'h2d + 6'(i), d);
            chk(d, {1'b0, 6'h2d + 6'(i), 9'h000});
        end
        $display("reset test done");
    endtask
    // Writes, dropped writes, unmapped read
    task t_rw;
        for (int i = 0; i < 3; i++) begin
            a = 6'h2d + 6'(i);
            host.wr(a, host.ent(a, 1'b1, 4'(i + 9), 4'(i + 5)));
            host.rd(a, d);
            chk(d, {1'b1, a, 1'b1, 4'(i + 9), 4'(i + 5)});
        end
        host.wr(6'h2e, 16'h5cff);
        host.wr(6'h2e, 16'hdbff);
        host.rd(6'h2e, d);
        chk(d, 16'hdda6);
        host.rd(6'h3f, d);
        chk(d, 16'h0000);
        $display("rw test done");
    endtask
    // Run the stack and follow its steps
    task t_seq(input [2:0] lp, input [7:0] steps);
        logic [1:0] s;
        for (int i = 0; i < 3; i++) begin
            a = 6'h2d + 6'(i);
            host.wr(a, host.ent(a, lp[i], 4'(2 * i + 2), 4'(2 * i + 1)));
        end
        host.wr(6'h3a, 16'h0001);
        for (int k = 0; k < 4; k++) begin
            s = steps[2 * k +: 2];
            wait_start();
            chk({6'h0, step_index_q, converter_b_channel_q, converter_a_channel_q},
                {6'h0, s, 4'(2 * s + 2), 4'(2 * s + 1)});
        end
        host.rd(6'h3a, d);
        chk(d, 16'h0001);
        host.wr(6'h3a, 16'h0000);
        repeat (150) @(posedge clk);
        #1;
        chk({14'h0, step_index_q}, 16'h0000);
        host.rd(6'h3b, d);
        chk(d, 16'h0000);
        $display("sequence test done");
    endtask
    task tally_and_finish;
        $display("compared %0d, mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // Main sequence
    initial begin
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        t_reset();
        t_rw();
        t_seq(3'b000, 8'h24);
        t_seq(3'b010, 8'h44);
        tally_and_finish();
    end
endmodule
